// *** rtl/isx_pkg.sv ***
// package for the isochronous split descriptor executor
// assumes one 40 MHz clock; descriptor loaded whole on a port
package isx_pkg;
    // descriptor word field positions (within 64-bit words)
    localparam int unsigned ACTIVE_BIT = 63;
    localparam int unsigned HALT_BIT = 62;
    localparam int unsigned BABBLE_BIT = 61;
    localparam int unsigned XERR_BIT = 60;
    localparam int unsigned PHASE_BIT = 59;
    localparam int unsigned TOGGLE_BIT = 57;
    localparam int unsigned SPLIT_BIT = 46;
    localparam logic [1:0] KIND_ISO = 2'h1;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN = 2'h1;
    localparam int unsigned ST_ERR = 0;
    localparam int unsigned ST_BABBLE = 1;
    localparam int unsigned ST_UNDER = 2;
    localparam int unsigned UFRAMES = 8;
    localparam logic [2:0] LAST_IN_SS = 3'h3;
    localparam logic [11:0] BYTES_RESET = 12'h000;
    localparam int unsigned FIFO_DEPTH = 4;
    // token-building clocks of 25 ns each, split token issue time
    localparam int unsigned TOKEN_NS = 100;
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned TOKEN_CYC = (TOKEN_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {ISX_IDLE, ISX_WAIT, ISX_SS, ISX_CS} isx_state_t;
endpackage

// *** rtl/isx_fifo.sv ***
// small valid/ready fifo for payload bytes
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/1ps
module isx_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    // ready is registered so the top's ready pin leaves a flip-flop
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign o_out_valid = (count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr];

    // pointers wrap; depth is assumed a power of two
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            o_in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

    // storage carries no reset
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule // isx_fifo

// *** rtl/isx_exec.sv ***
// executes one isochronous split descriptor, microframe by microframe
// assumes the descriptor arrives whole on i_load; link events are pulses
`timescale 1ns/1ps
module isx_exec (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic i_valid,
    input wire logic i_active,
    input wire logic [6:0] i_hub_id,
    input wire logic [6:0] i_hub_port_index,
    input wire logic i_split,
    input wire logic [1:0] i_endpoint_kind,
    input wire logic [1:0] i_token,
    input wire logic [6:0] i_function_id,
    input wire logic [3:0] i_endpoint_number,
    input wire logic [15:0] i_payload_buffer_offset,
    input wire logic [7:0] i_frame_field,
    input wire logic [7:0] i_start_split_mask,
    input wire logic [7:0] i_complete_split_mask,
    input wire logic i_data_toggle,
    input wire logic i_sof,
    input wire logic [4:0] i_bus_frame,
    input wire logic [2:0] i_bus_uframe,
    input wire logic i_done,
    input wire logic [7:0] i_rx_bytes,
    input wire logic i_rx_err,
    input wire logic i_rx_babble,
    input wire logic i_rx_stall,
    input wire logic i_tx_underrun,
    input wire logic i_data_valid,
    output logic o_data_ready,
    input wire logic [7:0] i_data,
    output logic o_token_valid,
    output logic o_token_in,
    output logic o_token_split,
    output logic o_token_complete,
    output logic [6:0] o_token_hub_id,
    output logic [6:0] o_token_hub_port_index,
    output logic [6:0] o_token_function_id,
    output logic [3:0] o_token_endpoint_number,
    output logic [15:0] o_mem_addr,
    output logic o_byte_valid,
    output logic [7:0] o_byte,
    input wire logic i_byte_ready,
    output logic o_valid,
    output logic o_active,
    output logic o_halt,
    output logic o_babble,
    output logic o_xact_err,
    output logic o_split_phase,
    output logic o_data_toggle,
    output logic [11:0] o_bytes_moved_count,
    output logic [7:0] o_start_split_mask,
    output logic [7:0] o_complete_split_mask,
    output logic [63:0] o_bytes_per_uframe,
    output logic [23:0] o_microframe_result
);
    typedef struct packed {
        isx_pkg::isx_state_t st;
        logic valid;
        logic active;
        logic is_in;
        logic split;
        logic halt;
        logic babble;
        logic xerr;
        logic phase;
        logic toggle;
        logic [11:0] moved;
        logic [7:0] ss_mask;
        logic [7:0] cs_mask;
        logic [63:0] counts;
        logic [23:0] result;
        logic [4:0] frame;
        logic [2:0] uf;
        logic tok_valid;
        logic byte_valid;
        logic [7:0] byte_q;
        logic [15:0] addr;
        logic [15:0] base;
        logic [6:0] hub;
        logic [6:0] port;
        logic [6:0] func;
        logic [3:0] ep;
    } isx_regs_t;

    isx_regs_t r;
    isx_regs_t next_r;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic frame_hit;
    logic runnable;

    // direction decode; the mask gate and the state both need it
    function automatic logic token_is_in(input logic [1:0] tok);
        return tok == isx_pkg::TOKEN_IN;
    endfunction

    // payload bytes pass the fifo; a stalled sink backs up to the source
    isx_fifo #(.WIDTH(8), .DEPTH(isx_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_in_valid(i_data_valid),
        .o_in_ready(o_data_ready),
        .i_in_data(i_data),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready),
        .o_out_data(f_data)
    );

    assign frame_hit = (i_bus_frame == r.frame);
    assign runnable = r.valid && r.active;
    // only OUT streams payload; the byte register takes one when empty
    assign f_ready = (!r.is_in) && (r.st == isx_pkg::ISX_SS)
        && (!r.byte_valid || i_byte_ready);

    always_comb begin
        next_r = r;
        next_r.tok_valid = 1'b0;
        if (r.byte_valid && i_byte_ready) begin
            next_r.byte_valid = 1'b0;
        end
        if (f_valid && f_ready) begin
            next_r.byte_valid = 1'b1;
            next_r.byte_q = f_data;
            next_r.addr = r.addr + 16'h0001;
        end
        if (i_load) begin
            // only isochronous split descriptors are accepted
            next_r.valid = i_valid && i_split
                && (i_endpoint_kind == isx_pkg::KIND_ISO);
            next_r.active = i_active;
            next_r.is_in = token_is_in(i_token);
            next_r.split = i_split;
            next_r.halt = 1'b0;
            next_r.babble = 1'b0;
            next_r.xerr = 1'b0;
            next_r.phase = 1'b0;
            next_r.toggle = i_data_toggle;
            next_r.moved = isx_pkg::BYTES_RESET;
            next_r.ss_mask = i_start_split_mask;
            // complete splits exist for IN only
            next_r.cs_mask = token_is_in(i_token)
                ? i_complete_split_mask : 8'h00;
            next_r.counts = 64'h0;
            next_r.result = 24'h0;
            next_r.frame = i_frame_field[7:3];
            next_r.base = i_payload_buffer_offset;
            next_r.addr = i_payload_buffer_offset;
            next_r.hub = i_hub_id;
            next_r.port = i_hub_port_index;
            next_r.func = i_function_id;
            next_r.ep = i_endpoint_number;
            next_r.st = isx_pkg::ISX_WAIT;
        end else begin
            unique case (r.st)
                isx_pkg::ISX_IDLE: begin
                end
                isx_pkg::ISX_WAIT: begin
                    if (!runnable) begin
                        next_r.st = isx_pkg::ISX_IDLE;
                    end else if ((r.ss_mask == 8'h00)
                        && (r.cs_mask == 8'h00)) begin
                        // whole descriptor done
                        next_r.valid = 1'b0;
                        next_r.active = 1'b0;
                        next_r.st = isx_pkg::ISX_IDLE;
                    end else if (i_sof && frame_hit) begin
                        next_r.uf = i_bus_uframe;
                        if (r.ss_mask[i_bus_uframe]) begin
                            next_r.phase = 1'b0;
                            next_r.tok_valid = 1'b1;
                            next_r.st = isx_pkg::ISX_SS;
                        end else if (r.cs_mask[i_bus_uframe]) begin
                            next_r.phase = 1'b1;
                            next_r.tok_valid = 1'b1;
                            next_r.st = isx_pkg::ISX_CS;
                        end
                    end
                end
                isx_pkg::ISX_SS, isx_pkg::ISX_CS: begin
                    if (i_done) begin
                        // record outcome for this microframe
                        next_r.result[3*r.uf +: 3] = {
                            i_tx_underrun && !r.is_in,
                            i_rx_babble && r.is_in,
                            i_rx_err};
                        next_r.babble = r.babble
                            | (i_rx_babble && r.is_in);
                        next_r.xerr = r.xerr | i_rx_err;
                        next_r.halt = r.halt | i_rx_stall;
                        next_r.toggle = ~r.toggle;
                        next_r.moved = r.moved
                            + {4'h0, i_rx_bytes};
                        // count byte lands on start and complete alike
                        next_r.counts[8*r.uf +: 8] = i_rx_bytes;
                        if (r.st == isx_pkg::ISX_SS) begin
                            next_r.ss_mask[r.uf] = 1'b0;
                        end else begin
                            next_r.cs_mask[r.uf] = 1'b0;
                        end
                        if (i_rx_stall) begin
                            // a stall is fatal: retire descriptor
                            next_r.valid = 1'b0;
                            next_r.active = 1'b0;
                            next_r.st = isx_pkg::ISX_IDLE;
                        end else begin
                            next_r.st = isx_pkg::ISX_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs other than o_data_ready all come from the state register
    assign o_token_valid = r.tok_valid;
    assign o_token_in = r.is_in;
    assign o_token_split = r.split;
    assign o_token_complete = r.phase;
    assign o_token_hub_id = r.hub;
    assign o_token_hub_port_index = r.port;
    assign o_token_function_id = r.func;
    assign o_token_endpoint_number = r.ep;
    assign o_mem_addr = r.addr;
    assign o_byte_valid = r.byte_valid;
    assign o_byte = r.byte_q;
    assign o_valid = r.valid;
    assign o_active = r.active;
    assign o_halt = r.halt;
    assign o_babble = r.babble;
    assign o_xact_err = r.xerr;
    assign o_split_phase = r.phase;
    assign o_data_toggle = r.toggle;
    assign o_bytes_moved_count = r.moved;
    assign o_start_split_mask = r.ss_mask;
    assign o_complete_split_mask = r.cs_mask;
    assign o_bytes_per_uframe = r.counts;
    assign o_microframe_result = r.result;
endmodule // isx_exec

// *** testbench/isx_far.sv ***
// far-side model: full-speed device seen through the translator
// assumes tokens arrive as one-cycle pulses on the host clock
`timescale 1ns/1ps
module isx_far (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_token_valid,
    input wire logic [3:0] i_lag,
    input wire logic [7:0] i_reply,
    input wire logic [3:0] i_flags,
    output logic o_done,
    output logic [7:0] o_rx_bytes,
    output logic [3:0] o_rx_flags
);
    logic [3:0] wait_cnt;
    logic busy;
    // answer each token after a chosen lag, prompt or slow
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            o_done <= 1'b0;
        end else begin
            o_done <= busy && wait_cnt == 4'h0;
            if (i_token_valid) begin
                busy <= 1'b1;
                wait_cnt <= i_lag;
            end else if (busy && wait_cnt == 4'h0) begin
                busy <= 1'b0;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
    // lines show the inverse outside the answer, so stale values never pass
    assign o_rx_bytes = o_done ? i_reply : ~i_reply;
    assign o_rx_flags = o_done ? i_flags : ~i_flags;
endmodule // isx_far

// *** testbench/isx_exec_sva.sv ***
// checker for the descriptor executor, top-level ports only
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/1ps
module isx_exec_chk (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [6:0] i_hub_id,
    input wire logic [1:0] i_token,
    input wire logic [7:0] i_frame_field,
    input wire logic i_sof,
    input wire logic [4:0] i_bus_frame,
    input wire logic [2:0] i_bus_uframe,
    input wire logic i_done,
    input wire logic i_rx_stall,
    input wire logic o_token_valid,
    input wire logic o_token_in,
    input wire logic o_token_complete,
    input wire logic [6:0] o_token_hub_id,
    input wire logic o_valid,
    input wire logic o_active,
    input wire logic o_halt,
    input wire logic o_babble,
    input wire logic o_xact_err,
    input wire logic o_split_phase,
    input wire logic o_data_toggle,
    input wire logic [7:0] o_start_split_mask,
    input wire logic [23:0] o_microframe_result
);
    logic [6:0] cap_hub;
    logic [1:0] cap_tok;
    logic [4:0] cap_frame;
    logic bab_any;
    logic err_any;
    logic ss_hit;
    // shadow of the fields that later tokens must carry
    always_ff @(posedge i_clk_sys) begin
        if (i_load) begin
            cap_hub <= i_hub_id;
            cap_tok <= i_token;
            cap_frame <= i_frame_field[7:3];
        end
    end
    // summaries are ors over all eight results
    assign bab_any = |(o_microframe_result & 24'h492492);
    assign err_any = |(o_microframe_result & 24'h249249);
    // start mask bit of the microframe now on the bus
    assign ss_hit = o_start_split_mask[i_bus_uframe];
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_token_one: assert property (
        o_token_valid |=> !o_token_valid)
        else $error("token pulse longer than one cycle");
    a_out_no_cs: assert property (
        o_token_valid && !o_token_in |-> !o_token_complete)
        else $error("complete split issued for out");
    a_phase_tok: assert property (
        o_token_valid |-> o_split_phase == !$past(ss_hit))
        else $error("split phase disagrees with start mask");
    a_token_live: assert property (
        o_token_valid |-> o_valid && o_active)
        else $error("token from idle descriptor");
    a_token_route: assert property (
        o_token_valid |-> o_token_hub_id == cap_hub
        && o_token_in == (cap_tok == isx_pkg::TOKEN_IN))
        else $error("token addressing wrong");
    a_token_frame: assert property (
        o_token_valid |-> $past(i_sof) && $past(i_bus_frame) == cap_frame)
        else $error("token without matching frame start");
    a_mask_clear: assert property (
        !$past(i_load)
        |-> (o_start_split_mask & ~$past(o_start_split_mask)) == 8'h00)
        else $error("start mask bit set by hardware");
    a_babble_sum: assert property (o_babble == bab_any)
        else $error("babble summary wrong");
    a_err_sum: assert property (o_xact_err == err_any)
        else $error("error summary wrong");
    a_halt_stall: assert property (
        i_done && i_rx_stall && o_valid |=> o_halt && !o_valid && !o_active)
        else $error("stall did not halt and retire");
    a_toggle_flip: assert property (
        i_done && o_valid |=> o_data_toggle != $past(o_data_toggle))
        else $error("toggle not written back");
    c_cs_token: cover property (o_token_valid && o_token_complete);
    c_out_token: cover property (o_token_valid && !o_token_in);
    c_halt: cover property ($rose(o_halt));
endmodule // isx_exec_chk
bind isx_exec isx_exec_chk u_isx_exec_chk (.*);

// *** testbench/test_iso_split_descriptor_exec.sv ***
// bench for the descriptor executor: splits, refusals, stall, fifo
// assumes the far-side model answers every token it sees
`timescale 1ns/1ps
module test_iso_split_descriptor_exec;
    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_load = 1'b0, i_sof = 1'b0;
    logic i_valid = 1'b1, i_active = 1'b1, i_split = 1'b1, seen = 1'b0;
    logic i_data_toggle = 1'b1, i_data_valid = 1'b0, i_byte_ready = 1'b0;
    logic i_done, i_rx_err, i_rx_babble, i_rx_stall, i_tx_underrun;
    logic o_data_ready, o_token_valid, o_token_in, o_token_split;
    logic o_token_complete, o_byte_valid, o_valid, o_active, o_halt;
    logic o_babble, o_xact_err, o_split_phase, o_data_toggle;
    logic [6:0] i_hub_id = 7'h2a, i_hub_port_index = 7'h05;
    logic [6:0] i_function_id = 7'h11, o_token_hub_id;
    logic [6:0] o_token_hub_port_index, o_token_function_id;
    logic [1:0] i_endpoint_kind = 2'h1, i_token = 2'h1;
    logic [3:0] i_endpoint_number = 4'h3, o_token_endpoint_number;
    logic [3:0] lag = 4'h0, flags = 4'h0, rx_flags;
    logic [15:0] i_payload_buffer_offset = 16'h0100, o_mem_addr;
    logic [7:0] i_frame_field = 8'h2d, i_start_split_mask = 8'h00;
    logic [7:0] i_complete_split_mask = 8'h00, i_rx_bytes, i_data = 8'h00;
    logic [7:0] o_byte, o_start_split_mask, o_complete_split_mask;
    logic [7:0] reply = 8'h00;
    logic [4:0] i_bus_frame = 5'h00;
    logic [2:0] i_bus_uframe = 3'h0;
    logic [11:0] o_bytes_moved_count;
    logic [63:0] o_bytes_per_uframe;
    logic [23:0] o_microframe_result;
    logic [7:0] got[$];
    int n_errors = 0, check_count = 0, k, n_in;
    isx_exec u_isx_exec (.*);
    isx_far u_isx_far (.i_clk_sys, .i_reset_n, .i_token_valid(o_token_valid),
        .i_lag(lag), .i_reply(reply), .i_flags(flags), .o_done(i_done),
        .o_rx_bytes(i_rx_bytes), .o_rx_flags(rx_flags));
    assign {i_tx_underrun, i_rx_stall, i_rx_babble, i_rx_err} = rx_flags;
    // 40 MHz system clock
    always #12.5 i_clk_sys = ~i_clk_sys;
    // note tokens and accepted payload bytes as they pass
    always @(posedge i_clk_sys) begin
        if (o_token_valid === 1'b1) seen <= 1'b1;
        if (o_byte_valid === 1'b1 && i_byte_ready === 1'b1) begin
            got.push_back(o_byte);
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, got_v);
        check_count++;
        if (got_v !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got_v);
        end
    endtask
    // inputs move 2 ns after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #2;
    endtask
    task automatic load(input logic [1:0] tok, kind, input logic [7:0] ss, cs);
        i_token = tok;
        i_endpoint_kind = kind;
        i_start_split_mask = ss;
        i_complete_split_mask = cs;
        i_load = 1'b1;
        step(1);
        i_load = 1'b0;
        step(1);
    endtask
    // one microframe start; waits, bounded, for the far side to finish
    task automatic uf(input logic [4:0] f, input logic [2:0] u, input logic t);
        seen = 1'b0;
        i_bus_frame = f;
        i_bus_uframe = u;
        i_sof = 1'b1;
        step(1);
        i_sof = 1'b0;
        for (k = 0; k < 24 && i_done !== 1'b1; k++) step(1);
        step(3);
        chk("token seen", t, seen);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog: the tests need a few hundred cycles
    initial begin
        repeat (3000) @(posedge i_clk_sys);
        n_errors++;
        complete_run();
    end
    initial begin
        step(8);
        i_reset_n = 1'b1;
        chk("ready after reset", 1'b1, o_data_ready);
        chk("idle after reset", 64'h0, {o_valid, o_active, o_halt,
            o_start_split_mask, o_microframe_result});
        // in: start split uframe 0, complete split uframe 2
        load(isx_pkg::TOKEN_IN, isx_pkg::KIND_ISO, 8'h01, 8'h04);
        reply = 8'h12;
        uf(5'h05, 3'h0, 1'b1);
        chk("start mask", 8'h00, o_start_split_mask);
        chk("count 0", 8'h12, o_bytes_per_uframe[7:0]);
        uf(5'h05, 3'h1, 1'b0);
        reply = 8'h34;
        flags = 4'h2;
        lag = 4'h5;
        uf(5'h05, 3'h2, 1'b1);
        chk("count 2", 8'h34, o_bytes_per_uframe[23:16]);
        chk("result 2", 3'h2, o_microframe_result[8:6]);
        chk("babble", 1'b1, o_babble);
        chk("toggle", 1'b1, o_data_toggle);
        chk("retired", 2'h0, {o_valid, o_active});
        chk("moved", 12'h046, o_bytes_moved_count);
        chk("phase", 1'b1, o_split_phase);
        chk("token route", {7'h05, 7'h11, 4'h3, 1'b1},
            {o_token_hub_port_index, o_token_function_id,
            o_token_endpoint_number, o_token_split});
        $display("test in_split done");
        // out: fill the fifo while the sink stalls, then send
        i_data_valid = 1'b1;
        n_in = 0;
        for (k = 0; k < 6; k++) begin
            i_data = 8'ha0 + n_in[7:0];
            if (o_data_ready === 1'b1) n_in++;
            step(1);
        end
        i_data_valid = 1'b0;
        chk("words taken", 4, n_in);
        load(isx_pkg::TOKEN_OUT, isx_pkg::KIND_ISO, 8'h02, 8'hff);
        chk("out cs mask", 8'h00, o_complete_split_mask);
        uf(5'h04, 3'h1, 1'b0);
        i_byte_ready = 1'b1;
        flags = 4'h9;
        lag = 4'h2;
        uf(5'h05, 3'h1, 1'b1);
        chk("result 1", 3'h5, o_microframe_result[5:3]);
        chk("error", 1'b1, o_xact_err);
        foreach (got[j]) chk("payload", 8'ha0 + j, got[j]);
        chk("payload count", isx_pkg::FIFO_DEPTH, got.size());
        chk("buffer address", 16'h0104, o_mem_addr);
        $display("test out_split done");
        // in: last start slot allowed, far side stalls
        load(isx_pkg::TOKEN_IN, isx_pkg::KIND_ISO, 8'h08, 8'h00);
        flags = 4'h4;
        uf(5'h05, 3'h3, 1'b1);
        chk("halt", 1'b1, o_halt);
        chk("stall retires", 1'b0, o_valid);
        $display("test stall done");
        // refused descriptors never issue tokens
        load(isx_pkg::TOKEN_IN, 2'h2, 8'h01, 8'h00);
        chk("bad kind", 1'b0, o_valid);
        uf(5'h05, 3'h0, 1'b0);
        i_split = 1'b0;
        load(isx_pkg::TOKEN_IN, isx_pkg::KIND_ISO, 8'h01, 8'h00);
        chk("no split", 1'b0, o_valid);
        uf(5'h05, 3'h0, 1'b0);
        i_split = 1'b1;
        i_active = 1'b0;
        load(isx_pkg::TOKEN_IN, isx_pkg::KIND_ISO, 8'h01, 8'h00);
        chk("inactive", 1'b0, o_active);
        uf(5'h05, 3'h0, 1'b0);
        $display("test refusals done");
        complete_run();
    end
endmodule // test_iso_split_descriptor_exec
